// file: buck_cfg_pkg.sv
// package: register map, field layout, reset values, timing and decode types for the buck config bank
package buck_cfg_pkg;

	// ****************************************
	// register byte addresses (byte indices scaled by four on apb)
	// ****************************************
	localparam logic [7:0] idx_reset_timer_config    = 8'h99;
	localparam logic [7:0] idx_buck_current_limit_a  = 8'h9a;
	localparam logic [7:0] idx_buck_current_limit_b  = 8'h9b;
	localparam logic [7:0] idx_buck_current_limit_c  = 8'h9c;
	localparam logic [7:0] idx_core_buck_two_config  = 8'h9d;
	localparam logic [7:0] idx_core_buck_one_config  = 8'h9e;
	localparam logic [7:0] idx_buck_status           = 8'ha8;
	localparam int         num_regs                  = 6;

	// ****************************************
	// field positions
	// ****************************************
	localparam int start_event_lsb = 6;
	localparam int delay_code_lsb  = 0;
	localparam int limit_hi_lsb    = 4;
	localparam int limit_lo_lsb    = 0;
	localparam int op_mode_lsb     = 6;
	localparam int pulldown_bit    = 5;
	localparam int feedback_lsb    = 0;

	// writable bits per register; reserved bits read zero
	localparam logic [7:0] conf_mask = 8'he7;
	localparam logic [7:0] full_mask = 8'hff;

	// reset values
	localparam logic [7:0] reset_val = 8'h00;
	localparam logic [7:0] core_conf_reset_val = 8'h01;

	// ****************************************
	// timing: one delay tick is 1.024 ms at 125 mhz
	// ****************************************
	localparam int  tick_ns        = 1024000;
	localparam int  clk_period_ns  = 8;
	localparam int  tick_cycles    = tick_ns / clk_period_ns;
	localparam logic [5:0] linear_top_code = 6'h20;
	localparam logic [5:0] linear_top_ticks = 6'h20;

	// current limits in ma
	localparam logic [12:0] base_limit_high_ma = 13'h05dc;
	localparam logic [12:0] base_limit_low_ma  = 13'h01f4;
	localparam logic [12:0] step_limit_ma      = 13'h0064;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ev_external_wake,
		ev_system_domain_powered,
		ev_power_domain_powered,
		ev_reset_state_exit
	} start_event_e;

	typedef enum logic [1:0] {
		mode_by_voltage_sel,
		mode_forced_sleep,
		mode_forced_sync,
		mode_automatic
	} op_mode_e;

	typedef struct packed {
		logic external_wake;
		logic system_domain_powered;
		logic power_domain_powered;
		logic reset_state_exit;
	} start_events_s;

	typedef struct packed {
		logic core_buck_merge_on;
		logic memory_io_merge_on;
		logic processor_full_current;
		logic core_full_current;
		logic core_dual_phase;
		logic core_one_enabled;
		logic core_two_enabled;
	} buck_ctrl_s;

	typedef struct packed {
		logic [12:0] memory_buck_limit_ma;
		logic [12:0] io_buck_limit_ma;
		logic [12:0] peripheral_buck_limit_ma;
		logic [12:0] processor_buck_limit_ma;
		logic [12:0] core_one_limit_ma;
		logic [12:0] core_two_limit_ma;
	} limits_s;

	typedef struct packed {
		op_mode_e   core_one_op_mode;
		op_mode_e   core_two_op_mode;
		logic       core_one_pulldown_en;
		logic       core_two_pulldown_en;
		logic [2:0] core_one_sense_src;
		logic [2:0] core_two_sense_src;
		logic       core_one_mixer_off;
		logic       core_one_diff_sense;
		logic       core_two_fb_invalid;
	} core_ctrl_s;

endpackage

// file: buck_config_reset_timer_regs.sv
// buck converter and reset-delay configuration register bank with apb slave and delay timer
//
// Contract
// - the start-event field picks which event starts the reset delay timer.
// - delay codes up to 0x20 count code times 1.024 ms.
// - each code above 0x20 adds a further 32.768 ms, reaching 1048.576 ms at all ones.
// - memory buck limit is 1500 ma plus 100 ma a step, doubled when merged with the io buck.
// - io and peripheral buck limits are 1500 ma plus 100 ma a step, never doubled.
// - processor buck limit is 500 ma plus 100 ma a step, doubled in full-current mode.
// - both core buck limits are 500 ma plus 100 ma a step, doubled in full-current mode.
// - core buck mode 00 follows voltage a/b, 01 sleep, 10 synchronous, 11 automatic.
// - pull-down is on while disabled unless its off bit is set; core two loses it in dual phase.
// - core two feedback bits add own output, core switch and peripheral switch; 000 is invalid.
// - core one feedback 000 turns the mixer off so it senses its own output when not merged.
// - core one feedback 000 with merge on selects differential remote sensing.
module buck_config_reset_timer_regs
	import buck_cfg_pkg::*;
#(
	parameter int tick_len = tick_cycles
) (
	// apb clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// system events and controls
	input  wire buck_cfg_pkg::start_events_s events,
	input  wire logic                    reset_pin_mode_sel,
	input  wire buck_cfg_pkg::buck_ctrl_s    ctrl,
	// decoded outputs
	output buck_cfg_pkg::limits_s         limits,
	output buck_cfg_pkg::core_ctrl_s      core_ctrl,
	output logic                         reset_delay_done,
	output logic                         event_combo_illegal
);
	import buck_cfg_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {
		tmr_idle,
		tmr_count,
		tmr_done
	} tmr_e;

	typedef struct packed {
		logic [num_regs-1:0][7:0] regs;
		tmr_e                     tstate;
		logic [10:0]              ticks_left;
		logic [16:0]              sub_cnt;
		logic [31:0]              rdata;
		logic                     err;
		logic                     combo_seen;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	logic       start_hit;
	logic [3:0] dec_idx;
	logic [2:0] reg_idx;
	logic       reg_hit;
	logic       status_hit;
	logic [10:0] delay_ticks;

	// byte address index from apb word address
	function automatic logic [3:0] decode_idx(input logic [11:0] a);
		logic [7:0] w;
		w = a[9:2];
		decode_idx = 4'hf;
		if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
			if (w >= idx_reset_timer_config && w <= idx_core_buck_one_config) begin
				decode_idx = {1'b0, 3'(w - idx_reset_timer_config)};
			end
		end
	endfunction

	// writable mask per register
	function automatic logic [7:0] wmask(input logic [2:0] i);
		wmask = (i >= 3'h4) ? conf_mask : full_mask;
	endfunction

	// limit in ma from base, code and doubling
	function automatic logic [12:0] limit_ma(input logic [12:0] base, input logic [3:0] code,
		input logic dbl);
		logic [12:0] v;
		v = base + 13'(code) * step_limit_ma;
		limit_ma = dbl ? 13'(v << 1) : v;
	endfunction

	// ****************************************
	// decode and next state
	// ****************************************
	assign dec_idx    = decode_idx(paddr);
	assign reg_idx    = dec_idx[2:0];
	assign reg_hit    = ~dec_idx[3];
	assign status_hit = (paddr[11:2] == {2'h0, idx_buck_status}) && (paddr[1:0] == 2'h0);

	// event pick for the timer start
	always_comb begin
		unique case (start_event_e'(st_r.regs[0][start_event_lsb +: 2]))
			ev_external_wake:         start_hit = events.external_wake;
			ev_system_domain_powered: start_hit = events.system_domain_powered;
			ev_power_domain_powered:  start_hit = events.power_domain_powered;
			ev_reset_state_exit:      start_hit = events.reset_state_exit;
		endcase
	end

	// delay in 1.024 ms ticks: linear to 0x20, then 32 ticks per code
	always_comb begin
		if (st_r.regs[0][5:0] <= linear_top_code) begin
			delay_ticks = {5'h00, st_r.regs[0][5:0]};
		end else begin
			delay_ticks = 11'({5'h00, st_r.regs[0][5:0] - linear_top_code} + 11'h001) << 5;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.err = 1'b0;
		// apb setup phase loads read data and error
		if (psel && !penable) begin
			st_nxt.err   = !(reg_hit || status_hit);
			st_nxt.rdata = 32'h0;
			if (reg_hit) begin
				st_nxt.rdata = {24'h0, st_r.regs[reg_idx] & wmask(reg_idx)};
			end else if (status_hit) begin
				st_nxt.rdata = {22'h0, st_r.combo_seen, reset_delay_done, st_r.tstate,
					st_r.ticks_left[5:0]};
			end
		end
		// writes land at the access edge
		if (psel && penable && pwrite && reg_hit && pstrb[0]) begin
			st_nxt.regs[reg_idx] = pwdata[7:0] & wmask(reg_idx);
		end
		// sticky flag of forbidden start event combination
		if (event_combo_illegal) begin
			st_nxt.combo_seen = 1'b1;
		end
		// delay timer
		unique case (st_r.tstate)
			tmr_idle: begin
				if (start_hit) begin
					st_nxt.ticks_left = delay_ticks;
					st_nxt.sub_cnt    = 17'(tick_len - 1);
					st_nxt.tstate     = (delay_ticks == 11'h0) ? tmr_done : tmr_count;
				end
			end
			tmr_count: begin
				if (st_r.sub_cnt == 17'h0) begin
					st_nxt.sub_cnt    = 17'(tick_len - 1);
					st_nxt.ticks_left = st_r.ticks_left - 11'h001;
					if (st_r.ticks_left == 11'h001) begin
						st_nxt.tstate = tmr_done;
					end
				end else begin
					st_nxt.sub_cnt = st_r.sub_cnt - 17'h00001;
				end
			end
			tmr_done: begin
				if (!start_hit) begin
					st_nxt.tstate = tmr_idle;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{regs: {core_conf_reset_val, core_conf_reset_val, reset_val, reset_val,
				reset_val, reset_val}, tstate: tmr_idle, ticks_left: 11'h0, sub_cnt: 17'h0,
				rdata: 32'h0, err: 1'b0, combo_seen: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata  = st_r.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && st_r.err;
	assign reset_delay_done = (st_r.tstate == tmr_done);
	assign event_combo_illegal = (st_r.regs[0][7:6] == 2'h3) && reset_pin_mode_sel;

	// current limits
	always_comb begin
		limits.memory_buck_limit_ma = limit_ma(base_limit_high_ma, st_r.regs[1][7:4],
			ctrl.memory_io_merge_on);
		limits.io_buck_limit_ma = limit_ma(base_limit_high_ma, st_r.regs[1][3:0], 1'b0);
		limits.peripheral_buck_limit_ma = limit_ma(base_limit_high_ma, st_r.regs[2][7:4], 1'b0);
		limits.processor_buck_limit_ma = limit_ma(base_limit_low_ma, st_r.regs[2][3:0],
			ctrl.processor_full_current);
		limits.core_two_limit_ma = limit_ma(base_limit_low_ma, st_r.regs[3][7:4],
			ctrl.core_full_current);
		limits.core_one_limit_ma = limit_ma(base_limit_low_ma, st_r.regs[3][3:0],
			ctrl.core_full_current);
	end

	// core buck modes, pull-downs and sensing
	always_comb begin
		core_ctrl.core_two_op_mode = op_mode_e'(st_r.regs[4][op_mode_lsb +: 2]);
		core_ctrl.core_one_op_mode = op_mode_e'(st_r.regs[5][op_mode_lsb +: 2]);
		core_ctrl.core_two_pulldown_en = !st_r.regs[4][pulldown_bit] && !ctrl.core_two_enabled
			&& !ctrl.core_dual_phase;
		core_ctrl.core_one_pulldown_en = !st_r.regs[5][pulldown_bit] && !ctrl.core_one_enabled;
		core_ctrl.core_two_sense_src = st_r.regs[4][2:0];
		core_ctrl.core_two_fb_invalid = (st_r.regs[4][2:0] == 3'h0);
		core_ctrl.core_one_mixer_off = (st_r.regs[5][2:0] == 3'h0);
		core_ctrl.core_one_sense_src = core_ctrl.core_one_mixer_off ? 3'h1 : st_r.regs[5][2:0];
		core_ctrl.core_one_diff_sense = core_ctrl.core_one_mixer_off
			&& ctrl.core_buck_merge_on;
	end

	// ****************************************
	// assertions
	// ****************************************
	a_write_readback: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && reg_hit && pstrb[0] |=> st_r.regs[$past(reg_idx)]
		== ($past(pwdata[7:0]) & wmask($past(reg_idx))))
		else $error("register write not stored");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r.regs[4][4:3] == 2'h0) && (st_r.regs[5][4:3] == 2'h0))
		else $error("reserved bits set");
	a_timer_zero: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_idle && start_hit && st_r.regs[0][5:0] == 6'h0 |=> reset_delay_done)
		else $error("zero delay not immediate");
	a_timer_ticks: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_idle && start_hit |=> st_r.ticks_left == $past(delay_ticks))
		else $error("delay tick count wrong");
	a_event_pick: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_idle && !start_hit |=> st_r.tstate == tmr_idle)
		else $error("timer started without event");
	a_mem_double: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.memory_io_merge_on |-> limits.memory_buck_limit_ma == 13'((13'h05dc
		+ 13'(st_r.regs[1][7:4]) * 13'h0064) << 1))
		else $error("merged memory limit wrong");
	a_io_limit: assert property (@(posedge pclk) disable iff (!presetn)
		limits.io_buck_limit_ma == 13'h05dc + 13'(st_r.regs[1][3:0]) * 13'h0064)
		else $error("io limit wrong");
	a_pro_limit: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.processor_full_current |-> limits.processor_buck_limit_ma
		== 13'h01f4 + 13'(st_r.regs[2][3:0]) * 13'h0064)
		else $error("processor limit wrong");
	a_core_limit: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.core_full_current |-> limits.core_one_limit_ma
		== 13'((13'h01f4 + 13'(st_r.regs[3][3:0]) * 13'h0064) << 1))
		else $error("core limit not doubled");
	a_dual_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.core_dual_phase |-> !core_ctrl.core_two_pulldown_en)
		else $error("pull-down in dual phase");
	a_diff_sense: assert property (@(posedge pclk) disable iff (!presetn)
		core_ctrl.core_one_diff_sense |-> ctrl.core_buck_merge_on && st_r.regs[5][2:0] == 3'h0)
		else $error("differential sense misselected");
	a_peri_limit: assert property (@(posedge pclk) disable iff (!presetn)
		limits.peripheral_buck_limit_ma == base_limit_high_ma + 13'(st_r.regs[2][7:4]) * step_limit_ma)
		else $error("peripheral limit wrong");
	a_mem_plain: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.memory_io_merge_on |-> limits.memory_buck_limit_ma == base_limit_high_ma
		+ 13'(st_r.regs[1][7:4]) * step_limit_ma) else $error("plain memory limit wrong");
	a_pro_double: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.processor_full_current |-> limits.processor_buck_limit_ma == 13'((base_limit_low_ma
		+ 13'(st_r.regs[2][3:0]) * step_limit_ma) << 1)) else $error("processor limit not doubled");
	a_core_two_limit: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.core_full_current |-> limits.core_two_limit_ma == base_limit_low_ma
		+ 13'(st_r.regs[3][7:4]) * step_limit_ma) else $error("core two limit wrong");
	a_fb_invalid: assert property (@(posedge pclk) disable iff (!presetn)
		core_ctrl.core_two_fb_invalid == (core_ctrl.core_two_sense_src == 3'h0))
		else $error("core two feedback invalid flag wrong");
	a_mixer_own: assert property (@(posedge pclk) disable iff (!presetn)
		core_ctrl.core_one_mixer_off && !ctrl.core_buck_merge_on |-> core_ctrl.core_one_sense_src
		== 3'h1 && !core_ctrl.core_one_diff_sense) else $error("core one own sense wrong");
	a_pulldown_off: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.regs[5][pulldown_bit] |-> !core_ctrl.core_one_pulldown_en)
		else $error("pull-down engaged although off");
	a_pulldown_on: assert property (@(posedge pclk) disable iff (!presetn)
		!st_r.regs[5][pulldown_bit] && !ctrl.core_one_enabled |-> core_ctrl.core_one_pulldown_en)
		else $error("pull-down missing while disabled");
	a_combo_flag: assert property (@(posedge pclk) disable iff (!presetn)
		event_combo_illegal |=> st_r.combo_seen)
		else $error("illegal combination not recorded");
	a_timer_start: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_idle && start_hit && delay_ticks != 11'h0 |=> st_r.tstate == tmr_count)
		else $error("timer did not start");
	a_done_release: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_done && !start_hit |=> st_r.tstate == tmr_idle)
		else $error("done held without event");
	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !reg_hit && !status_hit |-> pslverr)
		else $error("unmapped access without error");
	a_tick_hold: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.tstate == tmr_count && st_r.sub_cnt != 17'h0 |=> st_r.ticks_left == $past(st_r.ticks_left))
		else $error("tick count moved early");

endmodule // buck_config_reset_timer_regs

// file: buck_config_reset_timer_regs_test.sv
// self-checking testbench for the buck configuration and reset-delay register bank
module buck_config_reset_timer_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import buck_cfg_pkg::*;

	// ****************************************
	// signals and design instance
	// ****************************************
	localparam int tl = 4;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h00000000;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	start_events_s events = '0;
	logic          reset_pin_mode_sel = 1'b0;
	buck_ctrl_s    ctrl = '0;
	limits_s       limits;
	core_ctrl_s    core_ctrl;
	logic          reset_delay_done;
	logic          event_combo_illegal;
	int            n_errors = 0;
	int            n_checks = 0;
	int            k;
	int            j;
	logic [3:0]    c;
	logic [3:0]    d;
	logic [7:0]    rd_d;
	logic          err_d;

	buck_config_reset_timer_regs #(.tick_len(tl)) i_buck_config_reset_timer_regs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(events), .reset_pin_mode_sel(reset_pin_mode_sel),
		.ctrl(ctrl), .limits(limits), .core_ctrl(core_ctrl),
		.reset_delay_done(reset_delay_done), .event_combo_illegal(event_combo_illegal)
	);

	// 125 mhz clock
	always #4 pclk = ~pclk;

	// ****************************************
	// report, compare and bus tasks
	// ****************************************
	task final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen high at an edge
	task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			final_report();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd, rd_d, err_d);
	endtask

	task rchk(input logic [7:0] idx, input logic [7:0] exp, input logic eexp);
		apb(1'b0, idx, 8'h00, rd_d, err_d);
		check(rd_d, exp, "read data");
		check(err_d, eexp, "slave error");
	endtask

	function logic [31:0] lim(input int base, input logic [3:0] code, input logic dbl);
		lim = (base + 100 * code) << dbl;
	endfunction

	// runs the delay timer: a wrong event first, then the selected one
	task tmr(input logic [1:0] ev, input logic [5:0] code, input int ticks);
		int n;
		wr(8'h99, {ev, code});
		@(posedge pclk);
		events <= 4'b1000 >> (ev + 2'd1);
		reset_pin_mode_sel <= ev[0];
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		check(reset_delay_done, 1'b0, "started by wrong event");
		check(event_combo_illegal, ev == 2'b11, "combo flag");
		@(posedge pclk);
		events <= 4'b1000 >> ev;
		for (n = 1; n <= 5000; n++) begin
			@(posedge pclk);
			@(negedge pclk);
			if (reset_delay_done === 1'b1) break;
		end
		check(n >= ticks * tl - 1 && n <= ticks * tl + 3, 1'b1, "delay length");
		// a timer that never ends is already counted; stop the run here
		if (n > 5000) final_report();
		// status: done state, no ticks left
		rchk(8'ha8, 8'h80, 1'b0);
		@(posedge pclk);
		events <= '0;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		check(reset_delay_done, 1'b0, "done after event drop");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, full write and read-back, reserved bits
		for (k = 0; k < 6; k++) begin
			rchk(8'h99 + k[7:0], (k >= 4) ? 8'h01 : 8'h00, 1'b0);
			wr(8'h99 + k[7:0], 8'hff);
			rchk(8'h99 + k[7:0], (k >= 4) ? 8'he7 : 8'hff, 1'b0);
		end
		wr(8'ha0, 8'h5a);
		rchk(8'ha0, 8'h00, 1'b1);
		// current limit codes, plain and doubled
		for (k = 0; k < 16; k++) begin
			c = k[3:0];
			d = 4'hf - c;
			wr(8'h9a, {c, d});
			wr(8'h9b, {d, c});
			wr(8'h9c, {c, d});
			for (j = 0; j < 2; j++) begin
				@(posedge pclk);
				ctrl <= {7{j[0]}};
				@(negedge pclk);
				check(limits.memory_buck_limit_ma, lim(1500, c, j[0]), "mem");
				check(limits.io_buck_limit_ma, lim(1500, d, 1'b0), "io");
				check(limits.peripheral_buck_limit_ma, lim(1500, d, 1'b0), "peri");
				check(limits.processor_buck_limit_ma, lim(500, c, j[0]), "pro");
				check(limits.core_two_limit_ma, lim(500, c, j[0]), "core2");
				check(limits.core_one_limit_ma, lim(500, d, j[0]), "core1");
			end
		end
		// modes, pull-downs and feedback under merge, dual phase and enables
		for (j = 0; j < 4; j++) begin
			for (k = 0; k < 8; k++) begin
				wr(8'h9d, {k[1:0], k[2], 2'b11, k[2:0]});
				wr(8'h9e, {~k[1:0], ~k[2], 2'b11, k[2:0]});
				@(posedge pclk);
				ctrl <= {j[0], 3'b000, j[1], j == 3, j == 1};
				@(negedge pclk);
				check(core_ctrl.core_two_op_mode, k[1:0], "mode2");
				check(core_ctrl.core_one_op_mode, 2'(~k[1:0]), "mode1");
				check(core_ctrl.core_two_pulldown_en, ~k[2] & ~j[1] & (j != 1), "pd2");
				check(core_ctrl.core_one_pulldown_en, k[2] & (j != 3), "pd1");
				check(core_ctrl.core_two_fb_invalid, k == 0, "fb2 invalid");
				if (k != 0) check(core_ctrl.core_two_sense_src, k[2:0], "fb2");
				check(core_ctrl.core_one_mixer_off, k == 0, "mixer");
				check(core_ctrl.core_one_sense_src, (k == 0) ? 3'b001 : k[2:0], "fb1");
				check(core_ctrl.core_one_diff_sense, k == 0 && j[0], "diff");
			end
		end
		// delay timer: every start event, then the code boundaries
		@(posedge pclk);
		ctrl <= '0;
		for (k = 0; k < 4; k++) tmr(k[1:0], 6'h02, 2);
		tmr(2'b00, 6'h00, 0);
		tmr(2'b00, 6'h20, 32);
		tmr(2'b00, 6'h21, 64);
		tmr(2'b00, 6'h3f, 1024);
		final_report();
	end
endmodule // buck_config_reset_timer_regs_test
